// ---- shared/ext_port_map.svh ----
// register map, field positions, reset values and timing figures of the memory/board port
// assumes a 40 MHz single clock and 32-bit AXI4-Lite word addressing
`ifndef EXT_PORT_MAP_SVH
`define EXT_PORT_MAP_SVH
// register indexes; byte address is four times the index
`define SROM_BRD_CTL_IDX 8'h1E
`define BOARD_PORT_CTL_IDX 8'h1F
`define PORT_CFG_IDX 8'h20
// serial_rom_board_ctl fields
`define SRB_GRANT_BIT 7
`define SRB_REQ_BIT 6
`define SRB_MODE_BIT 5
`define SRB_READY_BIT 4
`define SRB_SEL_BIT 3
`define SRB_CLK_BIT 2
`define SRB_OUT_BIT 1
`define SRB_IN_BIT 0
`define SRB_RESET 8'h00
// board_port_ctl fields
`define BRD_DIR_BIT 1
`define BRD_STB_BIT 0
`define BRD_RESET 8'h00
// port_cfg fields
`define CFG_ALONE_BIT 0
`define CFG_PAR_EN_BIT 1
`define CFG_ROM_EN_BIT 2
`define CFG_PAR_ERR_BIT 3
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
// timing
`define CLK_MHZ 40
`define FLASH_ACCESS_NS 150
`define SRAM_ACCESS_NS 50
`endif

// ---- shared/ext_port_pkg.sv ----
// types shared by the memory/board port and its users
// assumes nothing beyond a SystemVerilog compiler
package ext_port_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_SETUP, ST_STROBE, ST_GAP, ST_DONE} port_state_t;

	// host memory access, held stable until answered
	typedef struct packed {
		logic valid;
		logic write;
		logic rom;
		logic wide;
		logic [16:0] addr;
		logic [7:0] wdata;
	} host_req_t;

	// one-cycle answer, the target-ready of the host cycle
	typedef struct packed {
		logic ready;
		logic refused;
		logic [63:0] rdata;
	} host_ans_t;

	// port strobes and address
	typedef struct packed {
		logic [15:0] addr;
		logic addr_oe;
		logic sram_select_n;
		logic boot_rom_select_n;
		logic port_read_write;
		logic serial_rom_select;
		logic port_request_n;
		logic board_write_enable;
		logic board_output_enable_n;
	} port_ctl_t;
endpackage

// ---- src/ext_memory_board_port.sv ----
// external memory and board-control port: SRAM, boot ROM/Flash, serial EEPROM and board logic
// assumes pins synchronous to ref_clk and an external arbiter on the same clock, if any
//
// Chosen here: the AXI4-Lite interface to the registers.
`include "ext_port_map.svh"

module ext_memory_board_port #(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// AXI4-Lite register slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// host memory accesses
	input wire ext_port_pkg::host_req_t host_req,
	output ext_port_pkg::host_ans_t host_ans,
	// port pins
	output ext_port_pkg::port_ctl_t port_ctl,
	input wire logic [7:0] port_data_lines_i,
	output logic [7:0] port_data_lines_o,
	output logic [7:0] port_data_lines_oe,
	input wire logic port_parity_line_i,
	output logic port_parity_line_o,
	output logic port_parity_line_oe,
	input wire logic port_grant_n,
	input wire logic sram_present_n
);
	// access lengths in cycles, rounded up, never below one
	localparam int FLASH_CYC_RAW = (`FLASH_ACCESS_NS * `CLK_MHZ + 999) / 1000;
	localparam int SRAM_CYC_RAW = (`SRAM_ACCESS_NS * `CLK_MHZ + 999) / 1000;
	localparam logic [3:0] FLASH_CYC = 4'(FLASH_CYC_RAW < 1 ? 1 : FLASH_CYC_RAW);
	localparam logic [3:0] SRAM_CYC = 4'(SRAM_CYC_RAW < 1 ? 1 : SRAM_CYC_RAW);

	generate
		if (ADDR_W < 10)
		begin : g_bad_addr
			$error("ADDR_W must be at least 10");
		end
	endgenerate

	// register state
	logic [7:0] srb_reg, srb_next;
	logic [7:0] brd_reg, brd_next;
	logic par_en_reg, par_en_next;
	logic rom_en_reg, rom_en_next;
	logic par_err_reg, par_err_next;
	logic alone_reg, alone_next;
	logic alone_seen_reg, alone_seen_next;
	// bus slave state
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [7:0] aw_idx_reg, aw_idx_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic wlane_reg, wlane_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	// access engine state
	ext_port_pkg::port_state_t state_reg, state_next;
	logic [16:0] addr_reg, addr_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [2:0] byte_reg, byte_next;
	logic [63:0] rbuf_reg, rbuf_next;
	logic refused_reg, refused_next;

	logic granted;
	logic board_mode;
	logic board_live;
	logic engine_busy;
	logic engine_drive;
	logic board_ready;
	logic do_write;
	logic [7:0] srb_view;
	logic [7:0] brd_view;
	logic [7:0] cfg_view;
	logic [2:0] last_byte;
	logic par_fault;

	assign granted = ~port_grant_n;
	assign board_mode = srb_reg[`SRB_MODE_BIT];
	assign engine_busy = state_reg != ext_port_pkg::ST_IDLE;
	// engine owns the lines only in the phases entered after the grant
	assign engine_drive = state_reg == ext_port_pkg::ST_SETUP ||
		state_reg == ext_port_pkg::ST_STROBE || state_reg == ext_port_pkg::ST_GAP;
	// board mode takes the lines only while the engine is idle and the grant holds
	assign board_live = board_mode & granted & ~engine_busy;
	assign board_ready = board_mode & granted;
	assign last_byte = host_req.wide ? 3'h7 : 3'h3;
	assign do_write = aw_have_reg & w_have_reg & ~bvalid_reg;

	// readback views
	always_comb
	begin
		srb_view = srb_reg;
		srb_view[`SRB_GRANT_BIT] = granted;
		srb_view[`SRB_REQ_BIT] = ~port_ctl.port_request_n;
		srb_view[`SRB_READY_BIT] = board_ready;
		// line 0 floats outside board mode, so it only reads back while board mode owns it
		srb_view[`SRB_IN_BIT] = board_live & port_data_lines_i[0];
		brd_view = brd_reg;
		if (brd_reg[`BRD_DIR_BIT])
		begin
			brd_view[7:3] = port_data_lines_i[7:3];
			brd_view[2] = port_parity_line_i;
		end
		cfg_view = 8'h00;
		cfg_view[`CFG_ALONE_BIT] = alone_reg;
		cfg_view[`CFG_PAR_EN_BIT] = par_en_reg;
		cfg_view[`CFG_ROM_EN_BIT] = rom_en_reg;
		cfg_view[`CFG_PAR_ERR_BIT] = par_err_reg;
	end

	// odd parity on the SRAM byte; a mismatch only counts when checking is enabled
	assign par_fault = state_reg == ext_port_pkg::ST_STROBE && cnt_reg == 4'h1 &&
		!addr_reg[16] && !host_req.rom && !host_req.write && par_en_reg &&
		port_parity_line_i != ~^port_data_lines_i;

	// bus slave and register next values
	always_comb
	begin
		srb_next = srb_reg;
		brd_next = brd_reg;
		par_en_next = par_en_reg;
		rom_en_next = rom_en_reg;
		par_err_next = par_err_reg | par_fault;
		alone_seen_next = 1'b1;
		// grant seen low before any request was made means it is strapped low
		alone_next = alone_seen_reg ? alone_reg : granted;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		aw_idx_next = aw_idx_reg;
		wbyte_next = wbyte_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_next = 1'b1;
			aw_idx_next = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_next = 1'b1;
			wbyte_next = s_axi_wdata[7:0];
			wlane_next = s_axi_wstrb[0];
		end
		if (do_write)
		begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = `RESP_OKAY;
			if (aw_idx_reg == `SROM_BRD_CTL_IDX)
			begin
				if (wlane_reg)
				begin
					srb_next[`SRB_MODE_BIT] = wbyte_reg[`SRB_MODE_BIT];
					srb_next[`SRB_SEL_BIT] = wbyte_reg[`SRB_SEL_BIT];
					srb_next[`SRB_CLK_BIT] = wbyte_reg[`SRB_CLK_BIT];
					srb_next[`SRB_OUT_BIT] = wbyte_reg[`SRB_OUT_BIT];
				end
			end
			else if (aw_idx_reg == `BOARD_PORT_CTL_IDX)
			begin
				if (wlane_reg)
					brd_next = wbyte_reg;
			end
			else if (aw_idx_reg == `PORT_CFG_IDX)
			begin
				if (wlane_reg)
				begin
					par_en_next = wbyte_reg[`CFG_PAR_EN_BIT];
					rom_en_next = wbyte_reg[`CFG_ROM_EN_BIT];
					// write one clears; a fault in the same cycle wins
					if (wbyte_reg[`CFG_PAR_ERR_BIT] && !par_fault)
						par_err_next = 1'b0;
				end
			end
			else
				bresp_next = `RESP_DECERR;
		end
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next = `RESP_OKAY;
			rdata_next = 32'h0000_0000;
			if (s_axi_araddr[9:2] == `SROM_BRD_CTL_IDX)
				rdata_next[7:0] = srb_view;
			else if (s_axi_araddr[9:2] == `BOARD_PORT_CTL_IDX)
				rdata_next[7:0] = brd_view;
			else if (s_axi_araddr[9:2] == `PORT_CFG_IDX)
				rdata_next[7:0] = cfg_view;
			else
				rresp_next = `RESP_DECERR;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
	end

	// bus slave and register flops
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			srb_reg <= `SRB_RESET;
			brd_reg <= `BRD_RESET;
			par_en_reg <= 1'b0;
			rom_en_reg <= 1'b0;
			par_err_reg <= 1'b0;
			alone_reg <= 1'b0;
			alone_seen_reg <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_idx_reg <= 8'h00;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `RESP_OKAY;
		end
		else
		begin
			srb_reg <= srb_next;
			brd_reg <= brd_next;
			par_en_reg <= par_en_next;
			rom_en_reg <= rom_en_next;
			par_err_reg <= par_err_next;
			alone_reg <= alone_next;
			alone_seen_reg <= alone_seen_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			aw_idx_reg <= aw_idx_next;
			wbyte_reg <= wbyte_next;
			wlane_reg <= wlane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// one outstanding write and one read; address and data accepted in either order
	assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_have_reg & ~bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// access engine: arbitrate, set up address and direction, strobe, release
	// host accesses wait while board mode owns the port, so software is never interrupted
	always_comb
	begin
		state_next = state_reg;
		addr_next = addr_reg;
		cnt_next = cnt_reg;
		byte_next = byte_reg;
		rbuf_next = rbuf_reg;
		refused_next = refused_reg;
		case (state_reg)
			ext_port_pkg::ST_IDLE:
			begin
				if (host_req.valid && !board_mode)
				begin
					addr_next = host_req.addr;
					byte_next = 3'h0;
					rbuf_next = 64'h0000_0000_0000_0000;
					refused_next = host_req.rom & ~rom_en_reg;
					state_next = (host_req.rom && !rom_en_reg) ?
						ext_port_pkg::ST_DONE : ext_port_pkg::ST_ARB;
				end
			end
			ext_port_pkg::ST_ARB:
			begin
				if (granted)
					state_next = ext_port_pkg::ST_SETUP;
			end
			ext_port_pkg::ST_SETUP:
			begin
				// direction settles one cycle before any select falls
				cnt_next = host_req.rom ? FLASH_CYC : SRAM_CYC;
				state_next = ext_port_pkg::ST_STROBE;
			end
			ext_port_pkg::ST_STROBE:
			begin
				cnt_next = cnt_reg - 4'h1;
				if (!host_req.write)
					rbuf_next[{byte_reg, 3'h0} +: 8] = port_data_lines_i;
				if (cnt_reg == 4'h1)
				begin
					if (host_req.rom && !host_req.write && byte_reg != last_byte)
					begin
						byte_next = byte_reg + 3'h1;
						addr_next = addr_reg + 17'h0_0001;
						state_next = ext_port_pkg::ST_SETUP;
					end
					else
						state_next = ext_port_pkg::ST_GAP;
				end
			end
			ext_port_pkg::ST_GAP:
				state_next = ext_port_pkg::ST_DONE;
			ext_port_pkg::ST_DONE:
				state_next = ext_port_pkg::ST_IDLE;
			default:
				state_next = ext_port_pkg::ST_IDLE;
		endcase
	end

	// access engine flops
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ext_port_pkg::ST_IDLE;
			addr_reg <= 17'h0_0000;
			cnt_reg <= 4'h0;
			byte_reg <= 3'h0;
			rbuf_reg <= 64'h0000_0000_0000_0000;
			refused_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			cnt_reg <= cnt_next;
			byte_reg <= byte_next;
			rbuf_reg <= rbuf_next;
			refused_reg <= refused_next;
		end
	end

	// host answer: target ready only after the strobe has ended, or with no strobe at all for a refused rom access
	assign host_ans.ready = state_reg == ext_port_pkg::ST_DONE;
	assign host_ans.refused = refused_reg;
	assign host_ans.rdata = rbuf_reg;

	// port strobes; sram and boot rom selects fall only in ST_STROBE, entered after the grant, and ignore a later loss of it
	always_comb
	begin
		port_ctl.addr = addr_reg[15:0];
		port_ctl.addr_oe = engine_drive;
		port_ctl.port_read_write = engine_drive ? ~host_req.write : 1'b1;
		// ram select serves sram reads and writes and the flash write strobe
		port_ctl.sram_select_n = ~(state_reg == ext_port_pkg::ST_STROBE &&
			(host_req.write || !host_req.rom));
		port_ctl.boot_rom_select_n = ~(state_reg == ext_port_pkg::ST_STROBE &&
			host_req.rom && !host_req.write);
		port_ctl.serial_rom_select = board_live & srb_reg[`SRB_SEL_BIT];
		// request holds for board mode and for any access under way
		port_ctl.port_request_n = ~(board_mode | (engine_busy &&
			state_reg != ext_port_pkg::ST_DONE));
		port_ctl.board_write_enable = board_live & brd_reg[`BRD_STB_BIT] &
			~brd_reg[`BRD_DIR_BIT];
		port_ctl.board_output_enable_n = board_live ? ~brd_reg[`BRD_DIR_BIT] : 1'b1;
	end

	// data and parity/A16 lines
	always_comb
	begin
		port_data_lines_o = 8'h00;
		port_data_lines_oe = 8'h00;
		port_parity_line_o = 1'b0;
		port_parity_line_oe = 1'b0;
		if (engine_drive)
		begin
			port_data_lines_o = host_req.wdata;
			port_data_lines_oe = {8{host_req.write}};
			if (host_req.rom)
			begin
				port_parity_line_o = addr_reg[16];
				port_parity_line_oe = 1'b1;
			end
			else if (host_req.write)
			begin
				port_parity_line_o = ~^host_req.wdata;
				port_parity_line_oe = 1'b1;
			end
		end
		else if (board_live)
		begin
			port_data_lines_o = {brd_reg[7:3], srb_reg[`SRB_CLK_BIT],
				srb_reg[`SRB_OUT_BIT], 1'b0};
			port_data_lines_oe = {{5{~brd_reg[`BRD_DIR_BIT]}}, 3'b110};
			port_parity_line_o = brd_reg[2];
			port_parity_line_oe = ~brd_reg[`BRD_DIR_BIT];
		end
	end
endmodule // ext_memory_board_port

// ---- tb/ext_port_chk.sv ----
// concurrent checks on the memory/board port pins and host answer
// assumes bind onto ext_memory_board_port, one clock ref_clk
module ext_port_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host side
	input wire ext_port_pkg::host_req_t host_req,
	input wire ext_port_pkg::host_ans_t host_ans,
	// port pins
	input wire ext_port_pkg::port_ctl_t port_ctl,
	input wire logic [7:0] port_data_lines_oe,
	input wire logic port_parity_line_o,
	input wire logic port_parity_line_oe,
	input wire logic port_grant_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// flash strobe is stretched to six cycles for a slow part
	sequence flash_low;
		!port_ctl.sram_select_n [*6] ##1 port_ctl.sram_select_n;
	endsequence
	sequence strobe_end;
		$rose(port_ctl.sram_select_n) && host_req.write;
	endsequence
	a_flash_pulse_len: assert property ($fell(port_ctl.sram_select_n) && host_req.rom |-> flash_low)
		else $error("flash strobe width wrong");
	a_ready_after_strobe: assert property (strobe_end |=> host_ans.ready)
		else $error("host ready not after strobe");
	a_rom_a16_line: assert property (!port_ctl.boot_rom_select_n |-> port_ctl.port_read_write
		&& port_parity_line_oe && port_parity_line_o == host_req.addr[16])
		else $error("rom cycle lines wrong");
	a_sram_parity_out: assert property (!port_ctl.sram_select_n && host_req.write && !host_req.rom
		|-> port_parity_line_oe && port_parity_line_o == ~^host_req.wdata)
		else $error("sram parity not driven");
	a_sram_addr_match: assert property (!port_ctl.sram_select_n |-> port_ctl.addr_oe
		&& port_ctl.addr == host_req.addr[15:0])
		else $error("sram address wrong");
	a_board_we_dir: assert property (port_ctl.board_write_enable |-> port_ctl.board_output_enable_n)
		else $error("board write while reading");
	a_board_read_free: assert property (!port_ctl.board_output_enable_n
		|-> port_data_lines_oe[7:3] == 5'h00 && !port_parity_line_oe)
		else $error("board lines driven in read");
	a_grant_owns: assert property (port_ctl.addr_oe || |port_data_lines_oe
		|| !port_ctl.sram_select_n |-> !port_grant_n || $past(!port_grant_n))
		else $error("port driven without grant");
endmodule // ext_port_chk

bind ext_memory_board_port ext_port_chk u_chk (.ref_clk(ref_clk), .rst(rst), .host_req(host_req),
	.host_ans(host_ans), .port_ctl(port_ctl), .port_data_lines_oe(port_data_lines_oe),
	.port_parity_line_o(port_parity_line_o), .port_parity_line_oe(port_parity_line_oe),
	.port_grant_n(port_grant_n));

// ---- tb/ext_port_partner.sv ----
// board side of the port: arbiter, 9-bit sram, boot rom, board latch, eeprom loopback
// assumes tri-state triples from the port; resolves each wire for the port's inputs
module ext_port_partner #(
	parameter logic [5:0] BOARD_IN = 6'h2D
) (
	// clock, reset and test knobs
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic alone,
	// port pins
	input wire ext_port_pkg::port_ctl_t port_ctl,
	input wire logic [7:0] port_data_lines_o,
	input wire logic [7:0] port_data_lines_oe,
	input wire logic port_parity_line_o,
	input wire logic port_parity_line_oe,
	output logic [7:0] data_wire,
	output logic par_wire,
	output logic port_grant_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] sram [0:16383];
	logic [7:0] pval;
	logic [7:0] last_d;
	logic ppar;
	logic last_p;
	logic grant_n_reg;
	logic [1:0] wait_cnt;
	function automatic logic [7:0] rom_byte(input logic [16:0] a);
		return a[7:0] ^ a[15:8] ^ {7'h00, a[16]};
	endfunction
	// released lines show the inverse of their last level, so stale data never reads back
	always_comb
	begin
		pval = ~last_d;
		ppar = ~last_p;
		if (!port_ctl.boot_rom_select_n)
			pval = rom_byte({port_parity_line_o, port_ctl.addr});
		else if (!port_ctl.sram_select_n && port_ctl.port_read_write)
			{ppar, pval} = sram[port_ctl.addr[13:0]];
		else if (!port_ctl.board_output_enable_n)
			{pval[7:3], ppar} = BOARD_IN;
		if (port_ctl.serial_rom_select)
			pval[0] = port_data_lines_o[1]; // eeprom echoes its input
	end
	assign data_wire = (port_data_lines_oe & port_data_lines_o) | (~port_data_lines_oe & pval);
	assign par_wire = port_parity_line_oe ? port_parity_line_o : ppar;
	assign port_grant_n = alone ? 1'b0 : grant_n_reg;
	// arbiter on the port clock; slow mode holds the grant back three cycles
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst || port_ctl.port_request_n)
		begin
			grant_n_reg <= 1'b1;
			wait_cnt <= 2'h0;
		end
		else if (wait_cnt == (slow ? 2'h3 : 2'h0))
			grant_n_reg <= 1'b0;
		else
			wait_cnt <= wait_cnt + 2'h1;
	end
	// 9-bit sram keeps the last byte seen while selected for writing
	// idle history starts known, else the inverted lines would stay unknown for ever
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			last_d <= 8'h00;
			last_p <= 1'b0;
		end
		else
		begin
			last_d <= data_wire;
			last_p <= par_wire;
		end
		if (!port_ctl.sram_select_n && !port_ctl.port_read_write)
			sram[port_ctl.addr[13:0]] <= {par_wire, data_wire};
	end
endmodule // ext_port_partner

// ---- tb/ext_memory_board_port_tb.sv ----
// self-checking bench: axi register access, host sram/rom/flash cycles, board mode
// assumes ext_port_partner on the pins and the bound checker
`include "ext_port_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module ext_memory_board_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] SRB = {`SROM_BRD_CTL_IDX, 2'b00};
	localparam logic [9:0] BRD = {`BOARD_PORT_CTL_IDX, 2'b00};
	localparam logic [9:0] CFG = {`PORT_CFG_IDX, 2'b00};
	logic ref_clk, rst, slow, alone, awv, wv, bry, arv, rry, seen;
	logic awr, wr_r, bv, arr, rv, pl_i, pl_o, pl_oe, gnt_n;
	logic [9:0] awa, ara;
	logic [31:0] wd, rdat, rd, seed;
	logic [1:0] br, rr, rresp;
	logic [7:0] dl_i, dl_o, dl_oe, d;
	logic [16:0] a;
	ext_port_pkg::host_req_t host_req;
	ext_port_pkg::host_ans_t host_ans, got;
	ext_port_pkg::port_ctl_t port_ctl;
	int n_errors = 0;
	int check_count = 0;
	ext_memory_board_port uut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.host_req(host_req), .host_ans(host_ans), .port_ctl(port_ctl), .port_data_lines_i(dl_i),
		.port_data_lines_o(dl_o), .port_data_lines_oe(dl_oe), .port_parity_line_i(pl_i),
		.port_parity_line_o(pl_o), .port_parity_line_oe(pl_oe), .port_grant_n(gnt_n),
		.sram_present_n(1'b0));
	ext_port_partner u_far (.ref_clk(ref_clk), .rst(rst), .slow(slow), .alone(alone),
		.port_ctl(port_ctl), .port_data_lines_o(dl_o), .port_data_lines_oe(dl_oe),
		.port_parity_line_o(pl_o), .port_parity_line_oe(pl_oe), .data_wire(dl_i),
		.par_wire(pl_i), .port_grant_n(gnt_n));
	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected rom packing, byte k from address a+k
	function automatic logic [63:0] rom_exp(input logic [16:0] a, input logic wide);
		logic [16:0] x;
		rom_exp = 64'h0;
		for (int k = 0; k < (wide ? 8 : 4); k++)
		begin
			x = a + 17'(k);
			rom_exp[8*k +: 8] = x[7:0] ^ x[15:8] ^ {7'h00, x[16]};
		end
	endfunction
	task automatic axi_wr(input logic [9:0] ad, input logic [7:0] dv);
		logic aw_ok, w_ok;
		@(posedge ref_clk);
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awa <= ad;
		wd <= {24'h0, dv};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge ref_clk);
			if (awv && awr === 1'b1)
			begin
				aw_ok = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr_r === 1'b1)
			begin
				w_ok = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (bv !== 1'b1);
		bry <= 1'b0;
	endtask
	task automatic axi_rd(input logic [9:0] ad);
		@(posedge ref_clk);
		ara <= ad;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge ref_clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge ref_clk); while (rv !== 1'b1);
		rd = rdat;
		rr = rresp;
		rry <= 1'b0;
	endtask
	task automatic host_op(input logic w, input logic rom, input logic wide);
		@(posedge ref_clk);
		host_req <= '{1'b1, w, rom, wide, a, d};
		do @(posedge ref_clk); while (host_ans.ready !== 1'b1);
		got = host_ans;
		host_req.valid <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		n_errors++;
		print_verdict();
	end
	// main sequence
	initial
	begin
		{ref_clk, slow, alone, awv, wv, bry, arv, rry} = 8'h00;
		{awa, ara, wd, a, d} = '0;
		host_req = '0;
		seed = 32'h986E44A0;
		rst = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		axi_rd(SRB);
		`CHK("srb reset", `SRB_RESET, rd[7:0])
		axi_rd(CFG);
		`CHK("cfg reset", 8'h00, rd[7:0])
		axi_rd(10'h084);
		`CHK("unmapped", {`RESP_DECERR, 32'h0}, {rr, rd})
		axi_wr(10'h084, 8'h00);
		`CHK("unmapped wr", `RESP_DECERR, br)
		$display("test reset done");
		axi_wr(CFG, 8'h06); // 9-bit sram fitted, so check parity
		`CHK("cfg wr", `RESP_OKAY, br)
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			slow <= seed[20];
			a = (i == 0) ? 17'h03FFF : {3'b000, seed[13:0]};
			d = seed[31:24];
			host_op(1'b1, 1'b0, 1'b0);
			host_op(1'b0, 1'b0, 1'b0);
			`CHK("sram rd", d, got.rdata[7:0])
		end
		axi_rd(CFG);
		`CHK("no parity err", 8'h06, rd[7:0])
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			a = (i == 0) ? 17'h1FFF8 : {seed[16:3], 3'b000};
			host_op(1'b0, 1'b1, i[0]);
			`CHK("rom rd", rom_exp(a, i[0]), got.rdata & {{32{i[0]}}, 32'hFFFFFFFF})
		end
		host_op(1'b1, 1'b1, 1'b0);
		`CHK("flash wr", 1'b0, got.refused)
		axi_wr(CFG, 8'h02);
		host_op(1'b0, 1'b1, 1'b0);
		`CHK("rom off", 1'b1, got.refused)
		$display("test memory done");
		slow <= 1'b1;
		axi_wr(SRB, 8'h2E);
		`CHK("request", 1'b0, port_ctl.port_request_n)
		do axi_rd(SRB); while (rd[`SRB_READY_BIT] !== 1'b1); // wait for ready first
		`CHK("srb status", 5'h1F, {rd[7:4], rd[0]})
		`CHK("eeprom pins", 2'h3, dl_o[2:1] & dl_oe[2:1])
		axi_wr(BRD, 8'hB5);
		repeat (2) @(posedge ref_clk);
		`CHK("brd drive", {5'h16, 1'b1, 5'h1F, 1'b1}, {dl_o[7:3], pl_o, dl_oe[7:3], pl_oe})
		`CHK("brd strobe", 2'h3, {port_ctl.board_write_enable, port_ctl.board_output_enable_n})
		axi_wr(BRD, 8'h02);
		axi_rd(BRD);
		`CHK("brd read", 6'h2D, rd[7:2])
		host_req <= '{1'b1, 1'b0, 1'b0, 1'b0, 17'h00055, 8'h00};
		seen = 1'b0;
		repeat (12)
		begin
			@(posedge ref_clk);
			seen = seen | (host_ans.ready === 1'b1);
		end
		`CHK("held off", 1'b0, seen)
		axi_wr(SRB, 8'h00); // leave board mode promptly
		do @(posedge ref_clk); while (host_ans.ready !== 1'b1);
		host_req.valid <= 1'b0;
		$display("test board done");
		alone <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		axi_rd(CFG);
		`CHK("alone flag", 1'b1, rd[`CFG_ALONE_BIT])
		a = 17'h00123;
		d = 8'hA7;
		host_op(1'b1, 1'b0, 1'b0);
		host_op(1'b0, 1'b0, 1'b0);
		`CHK("alone sram", 8'hA7, got.rdata[7:0])
		$display("test standalone done");
		print_verdict();
	end
endmodule // ext_memory_board_port_tb
